// >>> pkg/lrs_map.svh
// lrs_map.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the row sequencer design files
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH

`define LRS_OFS_CTRL      8'h00
`define LRS_OFS_PTR       8'h04
`define LRS_OFS_DATA      8'h08
`define LRS_OFS_STAT      8'h0c

`define LRS_CTRL_MODE_LSB 0
`define LRS_CTRL_BIAS_BIT 2
`define LRS_CTRL_EN_BIT   3
`define LRS_CTRL_IN_BIT   4
`define LRS_CTRL_OUT_BIT  5
`define LRS_CTRL_RST      6'h00
`define LRS_PTR_RST       6'h00

`define LRS_RAM_DEPTH     40
`define LRS_PTR_LIMIT     7'h28

`define LRS_STEP_STATIC   6'h08
`define LRS_STEP_MUX2     6'h04
`define LRS_STEP_MUX3     6'h03
`define LRS_STEP_MUX4     6'h02

`define LRS_CLK_NS        5
`define LRS_SLOT_NS       2500
`define LRS_SLOT_CYC      ((`LRS_SLOT_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS)

`endif

// >>> pkg/lrs_pkg.sv
// lrs_pkg: types shared by the row sequencer design files
// assumes lrs_map.svh supplies the numeric constants
package lrs_pkg;
    typedef enum logic [1:0] {
        LRS_STATIC,
        LRS_MUX2,
        LRS_MUX3,
        LRS_MUX4
    } lrs_mode_t;

    typedef logic [1:0] lrs_row_t;
endpackage : lrs_pkg

// >>> pkg/lrs_seq_if.sv
// lrs_seq_if: link between the core and the multiplex row sequencer
// assumes both ends run on mclk
`timescale 1ns/1ps
interface lrs_seq_if;
    import lrs_pkg::*;
    lrs_mode_t mode;
    logic      out_bank;
    logic      load;
    lrs_row_t  row_idx;
    lrs_row_t  sel_row;

    modport seq  (input mode, input out_bank, output load, output row_idx, output sel_row);
    modport core (output mode, output out_bank, input load, input row_idx, input sel_row);
endinterface : lrs_seq_if

// >>> logic/lrs_row_seq.sv
// lrs_row_seq: backplane slot timer, multiplex row index and output bank selector
// assumes mode and out_bank come from core control registers on mclk
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_row_seq
    import lrs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    lrs_seq_if.seq    sq
);
    localparam logic [8:0] SLOT_LAST = 9'(`LRS_SLOT_CYC - 1);

    logic [8:0] slot_q;
    lrs_row_t   row_q;
    logic       load_q;
    logic       slot_end;
    logic       bank_ok;
    logic       row_over;
    lrs_row_t   row_eff;

    function automatic lrs_row_t last_row(input lrs_mode_t m);
        case (m)
            LRS_STATIC: last_row = 2'h0;
            LRS_MUX2:   last_row = 2'h1;
            LRS_MUX3:   last_row = 2'h2;
            default:    last_row = 2'h3;
        endcase
    endfunction : last_row

    assign slot_end = (slot_q == SLOT_LAST);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            slot_q <= 9'h000;
        end else if (clk_en) begin
            slot_q <= slot_end ? 9'h000 : slot_q + 9'h001;
        end
    end

    // a mode change can leave the index above the new last row; >= folds it back
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            row_q <= 2'h0;
        end else if (clk_en && slot_end) begin
            row_q <= (row_q >= last_row(sq.mode)) ? 2'h0 : row_q + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            load_q <= 1'b0;
        end else if (clk_en) begin
            load_q <= slot_end;
        end
    end

    // banks exist only where two or fewer rows are multiplexed
    // until the index folds back, an out-of-range row is shown as row 0 so no
    // row outside the new mode ever reaches the selector, even for one load
    assign row_over   = (row_q > last_row(sq.mode));
    assign row_eff    = row_over ? 2'h0 : row_q;
    assign bank_ok    = (sq.mode == LRS_STATIC) || (sq.mode == LRS_MUX2);
    assign sq.sel_row = (bank_ok && sq.out_bank) ? (row_eff | 2'h2) : row_eff;
    assign sq.row_idx = row_eff;
    assign sq.load    = load_q;

    property p_mux3_no_row3;
        @(posedge mclk) disable iff (sys_rst)
        sq.mode == LRS_MUX3 |-> sq.sel_row != 2'h3;
    endproperty
    a_mux3_no_row3: assert property (p_mux3_no_row3)
        else $error("row 3 selected in 1:3 mode");

    sequence s_mux3_step;
        sq.mode == LRS_MUX3 && slot_end && clk_en && row_q == 2'h2;
    endsequence
    property p_mux3_wrap;
        @(posedge mclk) disable iff (sys_rst)
        s_mux3_step |=> row_q == 2'h0;
    endproperty
    a_mux3_wrap: assert property (p_mux3_wrap)
        else $error("1:3 sequence did not wrap to row 0");

    property p_static_row;
        @(posedge mclk) disable iff (sys_rst)
        sq.mode == LRS_STATIC && row_q == 2'h0 |-> sq.sel_row == (sq.out_bank ? 2'h2 : 2'h0);
    endproperty
    a_static_row: assert property (p_static_row)
        else $error("static mode row does not follow output bank");

    sequence s_mux4_step;
        sq.mode == LRS_MUX4 && slot_end && clk_en && row_q == 2'h3;
    endsequence
    property p_mux4_wrap;
        @(posedge mclk) disable iff (sys_rst)
        s_mux4_step |=> row_q == 2'h0;
    endproperty
    a_mux4_wrap: assert property (p_mux4_wrap)
        else $error("1:4 sequence did not wrap to row 0");

    property p_row_hold;
        @(posedge mclk) disable iff (sys_rst)
        !slot_end |=> $stable(row_q);
    endproperty
    a_row_hold: assert property (p_row_hold)
        else $error("row index moved inside a slot");
endmodule : lrs_row_seq

// >>> logic/lrs_ram_bank_core.sv
// lrs_ram_bank_core: display RAM, bank switching, display register and
// Wishbone classic register slave for the four-backplane segment driver
// assumes a classic single-cycle Wishbone master on mclk, byte addresses
//
// Operation
// - data bits falling past RAM address 39 are dropped, never wrapped
// - output selector picks one of four rows per address by mode and slot
// - 1:4 mode presents rows 0, 1, 2, 3 in turn, repeating
// - 1:3 mode cycles rows 0, 1, 2 and never presents row 3
// - 1:2 mode with output bank 0 alternates rows 0 and 1
// - static mode with output bank 0 always presents row 0
// - static mode with output bank 1 presents row 2 instead
// - 1:2 mode with output bank 1 presents rows 2 and 3
// - input bank 1 stores into row 2 (static) or rows 2, 3 (1:2)
// - input and output bank are separate settings
// - exactly two banks, 0 and 1, for input and for output
// - banks apply only in static and 1:2 modes
// - half bias in 1:2 mode closes the centre divider bypass switch
// - display register holds row data for its whole backplane slot
// - voltage selection follows the last written mode and bias
// - pointer advances 8, 4, 3 or 2 per byte by mode
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_ram_bank_core
    import lrs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [39:0] segment_output,
    output logic      [3:0]  backplane_output,
    output logic             bias_bypass,
    output logic      [1:0]  level_mode
);
    lrs_seq_if sq ();

    logic [3:0]  ram_q [`LRS_RAM_DEPTH];
    logic [5:0]  ctrl_q;
    logic [5:0]  ptr_q;
    logic [31:0] rdat_q;
    logic        ack_q;
    logic [39:0] disp_q;
    logic [3:0]  bp_q;
    logic        bypass_q;
    logic [1:0]  lvl_q;

    logic        req;
    logic        wr_ok;
    logic        rd_ok;
    logic        wr_ctrl;
    logic        wr_ptr;
    logic        wr_data;
    lrs_mode_t   mode;
    logic        bias_half;
    logic        disp_en;
    logic        in_bank;
    logic        in_bank_ok;
    logic [5:0]  step;
    logic [2:0]  per_col;

    // one ack per request; the idle cycle after ack keeps a held request from double-firing
    assign req     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ok   = req && wb_we_i && wb_sel_i[0];
    assign rd_ok   = req && !wb_we_i;
    assign wr_ctrl = wr_ok && (wb_adr_i == `LRS_OFS_CTRL);
    assign wr_ptr  = wr_ok && (wb_adr_i == `LRS_OFS_PTR);
    assign wr_data = wr_ok && (wb_adr_i == `LRS_OFS_DATA);

    assign mode       = lrs_mode_t'(ctrl_q[`LRS_CTRL_MODE_LSB +: 2]);
    assign bias_half  = ctrl_q[`LRS_CTRL_BIAS_BIT];
    assign disp_en    = ctrl_q[`LRS_CTRL_EN_BIT];
    assign in_bank    = ctrl_q[`LRS_CTRL_IN_BIT];
    assign in_bank_ok = in_bank && (mode == LRS_STATIC || mode == LRS_MUX2);

    assign sq.mode     = mode;
    assign sq.out_bank = ctrl_q[`LRS_CTRL_OUT_BIT];

    always_comb begin
        case (mode)
            LRS_STATIC: begin
                step    = `LRS_STEP_STATIC;
                per_col = 3'h1;
            end
            LRS_MUX2: begin
                step    = `LRS_STEP_MUX2;
                per_col = 3'h2;
            end
            LRS_MUX3: begin
                step    = `LRS_STEP_MUX3;
                per_col = 3'h3;
            end
            default: begin
                step    = `LRS_STEP_MUX4;
                per_col = 3'h4;
            end
        endcase
    end

    lrs_row_seq u_seq (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .sq      (sq)
    );

    // bank bits are single flops each: exactly two banks per direction
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= `LRS_CTRL_RST;
        end else if (clk_en && wr_ctrl) begin
            ctrl_q <= wb_dat_i[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ptr_q <= `LRS_PTR_RST;
        end else if (clk_en) begin
            if (wr_ptr) begin
                ptr_q <= wb_dat_i[5:0];
            end else if (wr_data) begin
                ptr_q <= ptr_q + step;
            end
        end
    end

    // byte is spread MSB first down each column, then across columns
    always_ff @(posedge mclk) begin
        logic [6:0] addr;
        logic [2:0] col;
        logic [1:0] row;
        addr = 7'h00;
        col  = 3'h0;
        row  = 2'h0;
        if (clk_en && wr_data) begin
            for (int j = 0; j < 8; j++) begin
                col  = 3'(j / int'(per_col));
                row  = 2'(j % int'(per_col)) | (in_bank_ok ? 2'h2 : 2'h0);
                addr = {1'b0, ptr_q} + {4'h0, col};
                if (addr < `LRS_PTR_LIMIT) begin
                    ram_q[addr[5:0]][row] <= wb_dat_i[7 - j];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= req;
        end
    end

    // unmapped and write-only offsets read as zero but are still acknowledged
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdat_q <= 32'h0000_0000;
        end else if (clk_en && rd_ok) begin
            case (wb_adr_i)
                `LRS_OFS_CTRL: rdat_q <= {26'h000_0000, ctrl_q};
                `LRS_OFS_PTR:  rdat_q <= {26'h000_0000, ptr_q};
                `LRS_OFS_STAT: rdat_q <= {16'h0000, 2'h0, ptr_q, 4'h0, sq.sel_row, sq.row_idx};
                default:       rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // reloaded only on the slot edge, so data stays put while its backplane is driven
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            disp_q <= 40'h00_0000_0000;
        end else if (clk_en && sq.load) begin
            for (int a = 0; a < `LRS_RAM_DEPTH; a++) begin
                disp_q[a] <= disp_en && ram_q[a][sq.sel_row];
            end
        end
    end

    // unused backplanes mirror active ones so they may be paired on glass
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bp_q <= 4'h0;
        end else if (clk_en && sq.load) begin
            if (!disp_en) begin
                bp_q <= 4'h0;
            end else begin
                case (mode)
                    LRS_STATIC: bp_q <= 4'hf;
                    LRS_MUX2:   bp_q <= sq.row_idx[0] ? 4'ha : 4'h5;
                    LRS_MUX3: begin
                        case (sq.row_idx)
                            2'h0:    bp_q <= 4'h1;
                            2'h1:    bp_q <= 4'ha;
                            default: bp_q <= 4'h4;
                        endcase
                    end
                    default:    bp_q <= 4'(4'h1 << sq.row_idx);
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bypass_q <= 1'b0;
            lvl_q    <= 2'h0;
        end else if (clk_en) begin
            bypass_q <= bias_half && (mode == LRS_MUX2);
            lvl_q    <= mode;
        end
    end

    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = rdat_q;
    assign segment_output   = disp_q;
    assign backplane_output = bp_q;
    assign bias_bypass      = bypass_q;
    assign level_mode       = lvl_q;

    property p_ptr_step;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && wr_data |=> ptr_q == $past(ptr_q) + $past(step);
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not advance by mode step");

    property p_bypass;
        @(posedge mclk) disable iff (sys_rst)
        clk_en ##1 clk_en |-> bias_bypass == ($past(bias_half) && $past(mode) == LRS_MUX2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("divider bypass does not match bias and mode");

    property p_disp_hold;
        @(posedge mclk) disable iff (sys_rst)
        !sq.load |=> $stable(segment_output);
    endproperty
    a_disp_hold: assert property (p_disp_hold)
        else $error("display register changed inside a slot");

    property p_bank_split;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && (wr_data || wr_ptr) |=> $stable(sq.out_bank);
    endproperty
    a_bank_split: assert property (p_bank_split)
        else $error("data write changed output bank");

    property p_bound;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && wr_data && ptr_q == 6'h27 && mode == LRS_MUX4 |=> $stable(ram_q[0]);
    endproperty
    a_bound: assert property (p_bound)
        else $error("surplus bits wrapped into address 0");

    property p_inbank_static;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && wr_data && mode == LRS_STATIC && in_bank && ptr_q < 6'h28
        |=> ram_q[$past(ptr_q)][2] == $past(wb_dat_i[7]);
    endproperty
    a_inbank_static: assert property (p_inbank_static)
        else $error("static input bank 1 not stored in row 2");

    sequence s_ack_req;
        wb_cyc_i && wb_stb_i && !ack_q && clk_en;
    endsequence
    property p_ack;
        @(posedge mclk) disable iff (sys_rst)
        s_ack_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack not a single pulse one cycle after request");

    property p_mux2_rows;
        @(posedge mclk) disable iff (sys_rst)
        mode == LRS_MUX2 |-> sq.sel_row == {sq.out_bank, sq.row_idx[0]};
    endproperty
    a_mux2_rows: assert property (p_mux2_rows)
        else $error("1:2 mode row not from the chosen output bank");

    property p_static_bank0;
        @(posedge mclk) disable iff (sys_rst)
        mode == LRS_STATIC && !sq.out_bank |-> sq.sel_row == 2'h0;
    endproperty
    a_static_bank0: assert property (p_static_bank0)
        else $error("static bank 0 row not 0");

    property p_mux2_bank0;
        @(posedge mclk) disable iff (sys_rst)
        mode == LRS_MUX2 && !sq.out_bank |-> sq.sel_row <= 2'h1;
    endproperty
    a_mux2_bank0: assert property (p_mux2_bank0)
        else $error("1:2 bank 0 row outside 0 and 1");

    property p_lvl;
        @(posedge mclk) disable iff (sys_rst)
        clk_en ##1 clk_en |-> level_mode == $past(mode);
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("level mode does not follow the written mode");

    property p_bp_mux4;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && sq.load && disp_en && mode == LRS_MUX4
        |=> backplane_output == 4'(4'h1 << $past(sq.row_idx));
    endproperty
    a_bp_mux4: assert property (p_bp_mux4)
        else $error("1:4 backplane not one-hot on the current row");

    property p_inbank_mux2;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && wr_data && mode == LRS_MUX2 && in_bank && ptr_q < 6'h28
        |=> ram_q[$past(ptr_q)][3] == $past(wb_dat_i[6]);
    endproperty
    a_inbank_mux2: assert property (p_inbank_mux2)
        else $error("1:2 input bank 1 not stored in row 3");

    property p_bank_ignored;
        @(posedge mclk) disable iff (sys_rst)
        (mode == LRS_MUX3 || mode == LRS_MUX4) |-> sq.sel_row == sq.row_idx;
    endproperty
    a_bank_ignored: assert property (p_bank_ignored)
        else $error("bank bit moved the row in 1:3 or 1:4 mode");

    property p_seg_row;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && sq.load && disp_en |=> segment_output[0] == $past(ram_q[0][sq.sel_row]);
    endproperty
    a_seg_row: assert property (p_seg_row)
        else $error("segment 0 not taken from the selected row");

    property p_rd_ptr;
        @(posedge mclk) disable iff (sys_rst)
        clk_en && rd_ok && wb_adr_i == `LRS_OFS_PTR
        |=> wb_dat_o == {26'h000_0000, $past(ptr_q)};
    endproperty
    a_rd_ptr: assert property (p_rd_ptr)
        else $error("pointer read back wrong");
endmodule : lrs_ram_bank_core

// >>> bench/lrs_host_model.sv
// lrs_host_model: host side of the row sequencer, issues classic Wishbone cycles
// assumes the core acks every request and the bench calls wr and rd
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_host_model (
    input  wire logic        mclk,
    input  wire logic        wb_ack_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic      [7:0]  wb_adr_o,
    output logic      [3:0]  wb_sel_o,
    output logic      [31:0] wb_dat_o,
    output logic             hung
);
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, hung} = 4'h0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    task automatic cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
        wb_adr_o <= a;
        wb_sel_o <= 4'h1;
        wb_dat_o <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 20);
        hung <= (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
        wb_sel_o <= 4'h0;
        // released data lines toggle so a stale value is never mistaken for a driven one
        wb_dat_o <= ~d;
    endtask : cycle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        cycle(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        cycle(1'b0, a, 32'h0, q);
    endtask : rd

    // bring-up order; no blink or init-RAM register exists, so those steps are empty
    task automatic init_seq();
        wr(8'h40, 32'h00);
        wr(`LRS_OFS_CTRL, 32'h03);
        wr(`LRS_OFS_PTR, 32'h00);
        wr(`LRS_OFS_DATA, 32'h53);
        wr(`LRS_OFS_CTRL, 32'h0b);
    endtask : init_seq
endmodule : lrs_host_model

// >>> bench/lrs_ram_bank_core_tb_top.sv
// lrs_ram_bank_core_tb_top: self-checking bench for the row sequencer core
// assumes a 500-cycle backplane slot and the host model as bus master
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_ram_bank_core_tb_top;
    logic        mclk, sys_rst, clk_en, wb_cyc, wb_stb, wb_we, wb_ack, hung, bias_bypass;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel, backplane_output;
    logic [31:0] wb_wdat, wb_rdat;
    logic [39:0] segment_output;
    logic [1:0]  level_mode;
    int          mismatches, checked;
    logic        stuck;

    lrs_ram_bank_core i_lrs_ram_bank_core (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .segment_output(segment_output), .backplane_output(backplane_output),
        .bias_bypass(bias_bypass), .level_mode(level_mode));
    lrs_host_model i_lrs_host_model (.mclk(mclk), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat),
        .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
        .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .hung(hung));

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    task automatic check(input logic [39:0] seen, input logic [39:0] want, input string what);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    always @(posedge hung or posedge stuck) begin
        mismatches++;
        conclude();
    end

    function automatic logic [3:0] bp_exp(input int m, input int r);
        case (m)
            1: return r[0] ? 4'ha : 4'h5;
            2: return (r == 1) ? 4'ha : 4'(4'h1 << r);
            default: return 4'(4'h1 << r);
        endcase
    endfunction : bp_exp

    // counts cycles until the backplane pattern moves; bounded so a stuck slot shows
    task automatic wait_load(output int c);
        logic [3:0] bp0;
        bp0 = backplane_output;
        c = 0;
        while (backplane_output === bp0 && c < 1200) begin
            @(posedge mclk);
            c++;
        end
        if (backplane_output === bp0) begin
            stuck = 1'b1;
        end
    endtask : wait_load

    task automatic test_regs();
        logic [31:0] d;
        int steps[4] = '{`LRS_STEP_STATIC, `LRS_STEP_MUX2, `LRS_STEP_MUX3, `LRS_STEP_MUX4};
        check(40'({bias_bypass, level_mode, backplane_output}), 40'h0, "reset outs");
        i_lrs_host_model.rd(`LRS_OFS_CTRL, d);
        check(40'(d), 40'h0, "reset ctrl");
        for (int m = 0; m < 4; m++) begin
            i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'(m) | 32'h10);
            i_lrs_host_model.wr(`LRS_OFS_PTR, 32'h10);
            i_lrs_host_model.wr(`LRS_OFS_DATA, 32'h00);
            i_lrs_host_model.rd(`LRS_OFS_PTR, d);
            check(40'(d), 40'h10 + 40'(steps[m]), "ptr step");
        end
        i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'h03);
        i_lrs_host_model.wr(`LRS_OFS_PTR, 32'h26);
        i_lrs_host_model.wr(`LRS_OFS_DATA, 32'hff);
        i_lrs_host_model.rd(`LRS_OFS_PTR, d);
        check(40'(d), 40'h28, "ptr past end");
        i_lrs_host_model.rd(`LRS_OFS_DATA, d);
        check(40'(d), 40'h0, "data read");
        i_lrs_host_model.rd(8'h40, d);
        check(40'(d), 40'h0, "unmapped read");
        $display("test regs done");
    endtask : test_regs

    // addr n shows row n in bits 1:0; addr 38 and 39 are all ones, 40 on were dropped
    task automatic watch(input int m, input logic ob);
        int c, n, rows;
        logic [39:0] seg;
        logic [1:0] want;
        rows = m + 1;
        n = 0;
        i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'(m) | 32'h0c | (ob ? 32'h20 : 32'h0));
        do begin
            wait_load(c);
            n++;
        end while (backplane_output !== bp_exp(m, 0) && n < 8);
        if (backplane_output !== bp_exp(m, 0)) begin
            stuck = 1'b1;
        end
        check(40'(level_mode), 40'(m), "level mode");
        check(40'(bias_bypass), 40'(m == 1), "bypass");
        for (int i = 0; i < 2 * rows; i++) begin
            want = 2'(i % rows + ((ob && m == 1) ? 2 : 0));
            check(40'(backplane_output), 40'(bp_exp(m, i % rows)), "backplane");
            check(40'({segment_output[39:38], segment_output[1:0]}), 40'({2'b11, want}),
                  "row data");
            seg = segment_output;
            repeat (400) @(posedge mclk);
            check(segment_output, seg, "held");
            wait_load(c);
            check(40'(400 + c), 40'(`LRS_SLOT_CYC), "slot length");
        end
        $display("test watch mode %0d bank %0d done", m, ob);
    endtask : watch

    // a byte straddling address 39 keeps its first column and loses the second
    task automatic test_boundary();
        logic [31:0] d;
        i_lrs_host_model.wr(`LRS_OFS_PTR, 32'h27);
        i_lrs_host_model.wr(`LRS_OFS_DATA, 32'hff);
        i_lrs_host_model.rd(`LRS_OFS_PTR, d);
        check(40'(d), 40'h29, "ptr straddle");
        i_lrs_host_model.rd(`LRS_OFS_STAT, d);
        check(40'(d), 40'h2900, "status");
        $display("test boundary done");
    endtask : test_boundary

    task automatic test_banks();
        i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'h18);
        i_lrs_host_model.wr(`LRS_OFS_PTR, 32'h08);
        i_lrs_host_model.wr(`LRS_OFS_DATA, 32'hf0);
        i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'h08);
        i_lrs_host_model.wr(`LRS_OFS_PTR, 32'h08);
        i_lrs_host_model.wr(`LRS_OFS_DATA, 32'h0f);
        repeat (2 * `LRS_SLOT_CYC) @(posedge mclk);
        check(40'(backplane_output), 40'hf, "static bp");
        check(40'({segment_output[15:8], segment_output[1:0]}), 40'h3c0, "bank 0");
        i_lrs_host_model.wr(`LRS_OFS_CTRL, 32'h28);
        repeat (2 * `LRS_SLOT_CYC) @(posedge mclk);
        check(40'({segment_output[15:8], segment_output[1:0]}), 40'h03e, "bank 1");
        $display("test banks done");
    endtask : test_banks

    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        mismatches = 0;
        checked = 0;
        stuck = 1'b0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        test_regs();
        i_lrs_host_model.init_seq();
        test_boundary();
        watch(3, 1'b1);
        watch(2, 1'b0);
        watch(1, 1'b0);
        watch(1, 1'b1);
        test_banks();
        conclude();
    end
endmodule : lrs_ram_bank_core_tb_top
